// [rtl/tpb_config_regs.v]
// tx pa bias, gain, lo phase and dc correction configuration registers with their source selection
`timescale 1ns/10ps
`default_nettype none
`include "tpb_map.vh"

// Function
// - delay code 0 and 1 give no delay, then 0.5us per code to 7.0us
// - dac output current is code times 5uA, zero to 315uA
// - register gain field is attenuation, zero least, all ones greatest and reset
// - gain source bit 0 uses gain pins, 1 uses register gain field
// - sixth gain input from its pin, or from gain field top bit when selected
// - dc offset correction from fuse trim, or from register fields when selected
// - lo i/q phase from internal trim, or from register phase field when selected
// - phase code 0 is +4 degrees, 15 is zero, 31 is -4 degrees
// - q dc code moves current split 32uA per step, 992/0 to 0/992
// - i dc field in low bits uses the same 32uA encoding
// - reset loads 0x0c0, 0x3f0, 0x080 and 0x000 into the four registers
module tpb_config_regs #(
   parameter DLY_STEP_CYCLES = `TPB_DLY_STEP_CYCLES
) (
   input  wire        clk_sys,
   input  wire        nrst,

   // serial control port
   input  wire        spi_cs_n,
   input  wire        spi_sclk,
   input  wire        spi_din,
   output wire        spi_dout,

   // transmit gain pins and pa enable request
   input  wire [4:0]  tx_gain_pins,
   input  wire        sixth_gain_pin,
   input  wire        pa_enable,

   // trim sources (static logic levels)
   input  wire [4:0]  fuse_dc_i,
   input  wire [4:0]  fuse_dc_q,
   input  wire [4:0]  trim_lo_phase,

   // analog controls
   output wire        pa_bias_dac_on,
   output reg  [8:0]  pa_bias_current_ua,
   output reg  [5:0]  tx_gain_atten,
   output reg  [4:0]  tx_dc_i_code,
   output reg  [4:0]  tx_dc_q_code,
   output reg  [9:0]  dc_i_pos_ua,
   output reg  [9:0]  dc_i_neg_ua,
   output reg  [9:0]  dc_q_pos_ua,
   output reg  [9:0]  dc_q_neg_ua,
   output reg  [4:0]  tx_lo_phase_code
);

   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   // the four configuration registers
   reg  [`TPB_REG_W-1:0]  pa_bias_dac_config;
   reg  [`TPB_REG_W-1:0]  tx_gain_config;
   reg  [`TPB_REG_W-1:0]  tx_lo_phase_config;
   reg  [`TPB_REG_W-1:0]  tx_dc_correction_config;

   // serial slave ports
   wire                   wr_stb;
   wire [`TPB_ADDR_W-1:0] wr_addr;
   wire [`TPB_REG_W-1:0]  wr_data;

   // read-back path
   wire [`TPB_ADDR_W-1:0] rd_addr;
   reg  [`TPB_REG_W-1:0]  rd_data;

   // pin synchronisers
   reg  [4:0]             gain_pins_s1;
   reg  [4:0]             gain_pins_s2;
   reg                    sixth_s1;
   reg                    sixth_s2;
   reg                    pa_en_s1;
   reg                    pa_en_s2;

   // selected values
   reg  [5:0]             next_atten;
   reg                    next_sixth;
   reg  [4:0]             next_dc_i;
   reg  [4:0]             next_dc_q;
   reg  [4:0]             next_phase;

   // ----------------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------------
   // negative leg of the dc offset split: 32uA per code step
   // code 0 gives 0uA, code 31 gives 992uA
   function [9:0] dc_neg_ua;
      input [4:0] code;
      begin
         dc_neg_ua = {code, {`TPB_DC_STEP_SHIFT{1'b0}}};
      end
   endfunction

   // positive leg: the full scale minus the negative leg
   // the two legs always sum to 992uA
   function [9:0] dc_pos_ua;
      input [4:0] code;
      begin
         dc_pos_ua = `TPB_DC_FULL_UA - dc_neg_ua(code);
      end
   endfunction

   // register read-back decode; unmapped addresses read as zero
   // offsets are distinct, so order is free
   function [`TPB_REG_W-1:0] read_mux;
      input [`TPB_ADDR_W-1:0] addr;
      input [`TPB_REG_W-1:0]  r_dac;
      input [`TPB_REG_W-1:0]  r_gain;
      input [`TPB_REG_W-1:0]  r_phase;
      input [`TPB_REG_W-1:0]  r_dc;
      begin
         if (addr == `TPB_OFS_PA_BIAS_DAC) begin
            read_mux = r_dac;
         end else if (addr == `TPB_OFS_TX_GAIN) begin
            read_mux = r_gain;
         end else if (addr == `TPB_OFS_TX_LO_PHASE) begin
            read_mux = r_phase;
         end else if (addr == `TPB_OFS_TX_DC_CORR) begin
            read_mux = r_dc;
         end else begin
            read_mux = `TPB_READ_UNMAPPED;
         end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------------------
   // one wr_stb per whole write frame
   tpb_spi_slave u_spi (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .spi_cs_n (spi_cs_n),
      .spi_sclk (spi_sclk),
      .spi_din  (spi_din),
      .spi_dout (spi_dout),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .wr_stb   (wr_stb),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data)
   );

   // read data feeds the slave's shifter, which drives the flop behind the pin
   // it is loaded once the header is in
   always @* begin
      rd_data = read_mux(rd_addr, pa_bias_dac_config, tx_gain_config,
                         tx_lo_phase_config, tx_dc_correction_config);
   end

   // ----------------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------------
   // all ten bits are kept as written, reserved ones included, so a read-back
   // shows the controller exactly what it left there
   // unmapped writes change nothing
   // a write lands a cycle after wr_stb
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pa_bias_dac_config      <= `TPB_RST_PA_BIAS_DAC;
         tx_gain_config          <= `TPB_RST_TX_GAIN;
         tx_lo_phase_config      <= `TPB_RST_TX_LO_PHASE;
         tx_dc_correction_config <= `TPB_RST_TX_DC_CORR;
      end else if (wr_stb) begin
         if (wr_addr == `TPB_OFS_PA_BIAS_DAC) begin
            pa_bias_dac_config <= wr_data;
         end else if (wr_addr == `TPB_OFS_TX_GAIN) begin
            tx_gain_config <= wr_data;
         end else if (wr_addr == `TPB_OFS_TX_LO_PHASE) begin
            tx_lo_phase_config <= wr_data;
         end else if (wr_addr == `TPB_OFS_TX_DC_CORR) begin
            tx_dc_correction_config <= wr_data;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------------
   // gain pins are asynchronous to clk_sys; a bus of pins may still be
   // caught mid-change for one cycle, the controller must hold them steady
   // reset levels match the idle pins
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gain_pins_s1 <= 5'h00;
         gain_pins_s2 <= 5'h00;

         sixth_s1     <= 1'b0;
         sixth_s2     <= 1'b0;

         pa_en_s1     <= 1'b0;
         pa_en_s2     <= 1'b0;
      end else begin
         gain_pins_s1 <= tx_gain_pins;
         gain_pins_s2 <= gain_pins_s1;

         sixth_s1     <= sixth_gain_pin;
         sixth_s2     <= sixth_s1;

         pa_en_s1     <= pa_enable;
         pa_en_s2     <= pa_en_s1;
      end
   end

   // ----------------------------------------------------------------------------
   // pa bias dac
   // ----------------------------------------------------------------------------
   // the timer counts from the synced enable
   // a new code takes effect at once
   // dropping pa_enable stops it at the third clock, once the two synchroniser stages pass it on
   tpb_turn_on_delay #(
      .STEP_CYCLES (DLY_STEP_CYCLES)
   ) u_delay (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .enable     (pa_en_s2),
      .delay_code (pa_bias_dac_config[`TPB_DLY_MSB:`TPB_DLY_LSB]),
      .dac_on     (pa_bias_dac_on)
   );

   // ----------------------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------------------
   // select bits act on the next clock
   always @* begin
      // sixth gain input: its own pin unless handed to the register top bit
      if (tx_gain_config[`TPB_SIXTH_SRC_BIT]) begin
         next_sixth = tx_gain_config[`TPB_GAIN_TOP_BIT];
      end else begin
         next_sixth = sixth_s2;
      end

      // whole gain word: pins or register attenuation field
      // sixth select is moot when gain source is 1
      if (tx_gain_config[`TPB_GAIN_SRC_BIT]) begin
         next_atten = tx_gain_config[`TPB_GAIN_MSB:`TPB_GAIN_LSB];
      end else begin
         next_atten = {next_sixth, gain_pins_s2};
      end

      // dc offset codes: fuse trim or register fields
      // fuse codes are static levels
      if (tx_gain_config[`TPB_DC_SRC_BIT]) begin
         next_dc_i = tx_dc_correction_config[`TPB_DCI_MSB:`TPB_DCI_LSB];
         next_dc_q = tx_dc_correction_config[`TPB_DCQ_MSB:`TPB_DCQ_LSB];
      end else begin
         next_dc_i = fuse_dc_i;
         next_dc_q = fuse_dc_q;
      end

      // lo phase: internal trim or register field; the code passes to the
      // phase network as is, +4 deg at 0, 0 deg at 15, -4 deg at 31
      if (tx_lo_phase_config[`TPB_PH_SRC_BIT]) begin
         next_phase = tx_lo_phase_config[`TPB_PH_MSB:`TPB_PH_LSB];
      end else begin
         next_phase = trim_lo_phase;
      end
   end

   // ----------------------------------------------------------------------------
   // analog control outputs
   // ----------------------------------------------------------------------------
   // registered so the analog side never sees decode glitches; costs one cycle
   // all outputs read zero in reset
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pa_bias_current_ua <= 9'h000;
         tx_gain_atten      <= 6'h00;
         tx_dc_i_code       <= 5'h00;
         tx_dc_q_code       <= 5'h00;

         dc_i_pos_ua        <= 10'h000;
         dc_i_neg_ua        <= 10'h000;
         dc_q_pos_ua        <= 10'h000;
         dc_q_neg_ua        <= 10'h000;

         tx_lo_phase_code   <= 5'h00;
      end else begin
         pa_bias_current_ua <= {3'h0, pa_bias_dac_config[`TPB_CUR_MSB:`TPB_CUR_LSB]}
                               * `TPB_CUR_STEP_UA;

         tx_gain_atten      <= next_atten;
         tx_dc_i_code       <= next_dc_i;
         tx_dc_q_code       <= next_dc_q;
         // dc legs from the selected codes
         dc_i_pos_ua        <= dc_pos_ua(next_dc_i);
         dc_i_neg_ua        <= dc_neg_ua(next_dc_i);
         dc_q_pos_ua        <= dc_pos_ua(next_dc_q);
         dc_q_neg_ua        <= dc_neg_ua(next_dc_q);

         tx_lo_phase_code   <= next_phase;
      end
   end

endmodule // tpb_config_regs
`default_nettype wire

// [common/tpb_map.vh]
// register map, field layout, reset values and timing constants of the tx bias and gain configuration bank
`ifndef TPB_MAP_VH
`define TPB_MAP_VH

// ----------------------------------------------------------------------------
// register offsets on the serial control port (5-bit address space)
// ----------------------------------------------------------------------------
`define TPB_ADDR_W              5
`define TPB_REG_W               10
`define TPB_OFS_PA_BIAS_DAC     5'h1c
`define TPB_OFS_TX_GAIN         5'h1d
`define TPB_OFS_TX_LO_PHASE     5'h1e
`define TPB_OFS_TX_DC_CORR      5'h1f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TPB_RST_PA_BIAS_DAC     10'h0c0
`define TPB_RST_TX_GAIN         10'h3f0
`define TPB_RST_TX_LO_PHASE     10'h080
`define TPB_RST_TX_DC_CORR      10'h000
`define TPB_READ_UNMAPPED       10'h000

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TPB_DLY_MSB             9
`define TPB_DLY_LSB             6
`define TPB_CUR_MSB             5
`define TPB_CUR_LSB             0
`define TPB_GAIN_MSB            9
`define TPB_GAIN_LSB            4
`define TPB_GAIN_TOP_BIT        9
`define TPB_DC_SRC_BIT          2
`define TPB_SIXTH_SRC_BIT       1
`define TPB_GAIN_SRC_BIT        0
`define TPB_PH_SRC_BIT          5
`define TPB_PH_MSB              4
`define TPB_PH_LSB              0
`define TPB_DCQ_MSB             9
`define TPB_DCQ_LSB             5
`define TPB_DCI_MSB             4
`define TPB_DCI_LSB             0

// ----------------------------------------------------------------------------
// serial frame layout: write flag, 5 address bits, 10 data bits, msb first
// ----------------------------------------------------------------------------
`define TPB_FRAME_LEN           5'h10
`define TPB_HDR_LEN             5'h06
`define TPB_FRAME_WR_BIT        15
`define TPB_FRAME_ADDR_MSB      14
`define TPB_FRAME_ADDR_LSB      10
`define TPB_FRAME_DATA_MSB      9
`define TPB_FRAME_DATA_LSB      0

// ----------------------------------------------------------------------------
// analog scaling and timing
// ----------------------------------------------------------------------------
`define TPB_CUR_STEP_UA         9'h005
`define TPB_DC_FULL_UA          10'h3e0
`define TPB_DC_STEP_SHIFT       5
`define TPB_CLK_PERIOD_NS       10
`define TPB_DLY_STEP_NS         500
`define TPB_DLY_STEP_CYCLES     ((`TPB_DLY_STEP_NS + `TPB_CLK_PERIOD_NS - 1) / `TPB_CLK_PERIOD_NS)
`define TPB_DLY_ZERO_CODE       4'h1

`endif

// [rtl/tpb_spi_slave.v]
// serial control port slave: pin synchronisers, frame shifter, write strobe and read-back shifter
`timescale 1ns/10ps
`default_nettype none
`include "tpb_map.vh"

module tpb_spi_slave (
   input  wire                     clk_sys,
   input  wire                     nrst,
   input  wire                     spi_cs_n,
   input  wire                     spi_sclk,
   input  wire                     spi_din,
   output reg                      spi_dout,
   output wire [`TPB_ADDR_W-1:0]   rd_addr,
   input  wire [`TPB_REG_W-1:0]    rd_data,
   output reg                      wr_stb,
   output reg  [`TPB_ADDR_W-1:0]   wr_addr,
   output reg  [`TPB_REG_W-1:0]    wr_data
);

   // ----------------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------------
   reg        cs_s1, cs_s2;
   reg        sck_s1, sck_s2, sck_d;
   reg        din_s1, din_s2;
   reg [15:0] shift;
   reg [4:0]  bit_cnt;
   reg        load_pend;
   reg [`TPB_REG_W-1:0] tx_shift;
   wire       sck_rise = sck_s2 & ~sck_d;
   wire       sck_fall = ~sck_s2 & sck_d;
   wire [15:0] next_shift = {shift[14:0], din_s2};

   // first stage is read only by the second stage
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_d  <= 1'b0;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         cs_s1  <= spi_cs_n;
         cs_s2  <= cs_s1;
         sck_s1 <= spi_sclk;
         sck_s2 <= sck_s1;
         sck_d  <= sck_s2;
         din_s1 <= spi_din;
         din_s2 <= din_s1;
      end
   end

   // address is live from the shifter once the header is in
   assign rd_addr = shift[`TPB_ADDR_W-1:0];

   // ----------------------------------------------------------------------------
   // frame shifter
   // ----------------------------------------------------------------------------
   // bits past the sixteenth are ignored; a frame cut short by cs never writes
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift     <= 16'h0000;
         bit_cnt   <= 5'h00;
         load_pend <= 1'b0;
         wr_stb    <= 1'b0;
         wr_addr   <= {`TPB_ADDR_W{1'b0}};
         wr_data   <= {`TPB_REG_W{1'b0}};
      end else begin
         wr_stb    <= 1'b0;
         load_pend <= 1'b0;
         if (cs_s2) begin
            bit_cnt <= 5'h00;
         end else if (sck_rise && bit_cnt != `TPB_FRAME_LEN) begin
            shift   <= next_shift;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `TPB_HDR_LEN - 5'h01 && !shift[`TPB_ADDR_W-1]) begin
               load_pend <= 1'b1;          // read header complete
            end
            if (bit_cnt == `TPB_FRAME_LEN - 5'h01 && next_shift[`TPB_FRAME_WR_BIT]) begin
               wr_stb  <= 1'b1;
               wr_addr <= next_shift[`TPB_FRAME_ADDR_MSB:`TPB_FRAME_ADDR_LSB];
               wr_data <= next_shift[`TPB_FRAME_DATA_MSB:`TPB_FRAME_DATA_LSB];
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // read-back shifter
   // ----------------------------------------------------------------------------
   // data changes on falling sclk so the controller can sample on rising sclk
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tx_shift <= {`TPB_REG_W{1'b0}};
         spi_dout <= 1'b0;
      end else if (cs_s2) begin
         tx_shift <= {`TPB_REG_W{1'b0}};
         spi_dout <= 1'b0;
      end else if (load_pend) begin
         tx_shift <= rd_data;
      end else if (sck_fall && bit_cnt >= `TPB_HDR_LEN) begin
         spi_dout <= tx_shift[`TPB_REG_W-1];
         tx_shift <= {tx_shift[`TPB_REG_W-2:0], 1'b0};
      end
   end

endmodule // tpb_spi_slave
`default_nettype wire

// [rtl/tpb_turn_on_delay.v]
// pa bias dac turn-on delay timer
`timescale 1ns/10ps
`default_nettype none
`include "tpb_map.vh"

module tpb_turn_on_delay #(
   parameter STEP_CYCLES = `TPB_DLY_STEP_CYCLES
) (
   input  wire       clk_sys,
   input  wire       nrst,
   input  wire       enable,
   input  wire [3:0] delay_code,
   output reg        dac_on
);

   reg  [9:0] count;
   reg  [9:0] target;

   // ----------------------------------------------------------------------------
   // target: codes 0 and 1 give no delay, then one half-microsecond per code
   // ----------------------------------------------------------------------------
   always @* begin
      if (delay_code <= `TPB_DLY_ZERO_CODE) begin
         target = 10'h000;
      end else begin
         target = {6'h00, delay_code - `TPB_DLY_ZERO_CODE} * STEP_CYCLES[9:0];
      end
   end

   // count while enabled; dropping enable turns the dac off at once
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count  <= 10'h000;
         dac_on <= 1'b0;
      end else if (!enable) begin
         count  <= 10'h000;
         dac_on <= 1'b0;
      end else if (count >= target) begin
         dac_on <= 1'b1;
      end else begin
         count  <= count + 10'h001;
      end
   end

endmodule // tpb_turn_on_delay
`default_nettype wire

// [sim/tpb_config_props.sv]
// assertions on the ports of the tx bias and gain configuration bank
`timescale 1ns/10ps
`default_nettype none
module tpb_config_chk (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       spi_cs_n,
   input wire logic       spi_dout,
   input wire logic       pa_enable,
   input wire logic [4:0] fuse_dc_i,
   input wire logic [4:0] trim_lo_phase,
   input wire logic       pa_bias_dac_on,
   input wire logic [8:0] pa_bias_current_ua,
   input wire logic [4:0] tx_dc_i_code,
   input wire logic [4:0] tx_dc_q_code,
   input wire logic [9:0] dc_i_pos_ua,
   input wire logic [9:0] dc_i_neg_ua,
   input wire logic [9:0] dc_q_pos_ua,
   input wire logic [9:0] dc_q_neg_ua,
   input wire logic [4:0] tx_lo_phase_code
);
   // ------------------------------------------------------------
   // checks, all in the system clock domain
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // two low samples, so the async clear has surely landed
   a_reset_quiet: assert property (disable iff (1'b0)
      !nrst ##1 !nrst |-> dc_q_pos_ua == 10'h000 && !pa_bias_dac_on) else $error("outputs not clear in reset");
   a_trim_after_reset: assert property ($rose(nrst) |=>
      tx_dc_i_code == $past(fuse_dc_i) && tx_lo_phase_code == $past(trim_lo_phase)) else $error("trim not used");
   a_dc_i_split: assert property ($past(nrst) |-> dc_i_neg_ua == {tx_dc_i_code, 5'h00} &&
      dc_i_pos_ua == 10'h3e0 - dc_i_neg_ua) else $error("i current split wrong");
   a_dc_q_split: assert property ($past(nrst) |-> dc_q_neg_ua == {tx_dc_q_code, 5'h00} &&
      dc_q_pos_ua == 10'h3e0 - dc_q_neg_ua) else $error("q current split wrong");
   a_current_step: assert property (
      pa_bias_current_ua % 9'h005 == 9'h000 && pa_bias_current_ua <= 9'h13b) else $error("current off grid");
   a_dac_off_idle: assert property (
      !pa_enable [*5] |-> !pa_bias_dac_on) else $error("dac on without request");
   a_dac_rise_cause: assert property (
      $rose(pa_bias_dac_on) |-> pa_enable && $past(pa_enable, 2)) else $error("dac on too early");
   a_dout_idle: assert property (
      spi_cs_n [*5] |-> !spi_dout) else $error("read line busy outside frame");
endmodule // tpb_config_chk
`default_nettype wire

// [sim/tpb_ctrl_model.sv]
// baseband controller model driving frames on the serial control port
`timescale 1ns/10ps
`default_nettype none
module tpb_ctrl_model (
   input  wire logic clk_sys,
   output var  logic spi_cs_n,
   output var  logic spi_sclk,
   output var  logic spi_din,
   input  wire logic spi_dout
);
   // ------------------------------------------------------------
   // frame driver
   // ------------------------------------------------------------
   // six clocks a half period leaves margin over the pin synchronisers
   localparam int HALF = 6;
   // idle: deselected, serial clock stands still low
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_din  = 1'b0;
   end
   // write flag, address, data msb first; read bits taken at rising sclk 7 to 16
   task automatic xfer(input logic wr, input logic [4:0] addr, input logic [9:0] wdata, output logic [9:0] rdata);
      logic [15:0] frm;
      frm = {wr, addr, wdata};
      rdata = 10'h000;
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_din  <= frm[i];
         spi_sclk <= 1'b0;
         repeat (HALF) @(posedge clk_sys);
         spi_sclk <= 1'b1;
         if (i < 10) rdata[i] = spi_dout;
         repeat (HALF) @(posedge clk_sys);
      end
      spi_sclk <= 1'b0;
      spi_din  <= ~frm[0]; // released line must not keep the last bit
      repeat (HALF) @(posedge clk_sys);
      spi_cs_n <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
   endtask
endmodule // tpb_ctrl_model
`default_nettype wire

// [sim/test_tx_pa_bias_config_regs.sv]
// self-checking bench for the tx bias and gain configuration bank
`timescale 1ns/10ps
`default_nettype none
module test_tx_pa_bias_config_regs;
   localparam int STEP = 2;
   logic       clk_sys, nrst, spi_cs_n, spi_sclk, spi_din, spi_dout, sixth_gain_pin, pa_enable, pa_bias_dac_on;
   logic [4:0] tx_gain_pins, fuse_dc_i, fuse_dc_q, trim_lo_phase, tx_dc_i_code, tx_dc_q_code, tx_lo_phase_code;
   logic [8:0] pa_bias_current_ua;
   logic [5:0] tx_gain_atten;
   logic [9:0] dc_i_pos_ua, dc_i_neg_ua, dc_q_pos_ua, dc_q_neg_ua, rd;
   int         errors = 0, checked = 0, cycles = 0;
   // short delay step keeps the turn-on timing test brief
   tpb_config_regs #(.DLY_STEP_CYCLES(STEP)) dut_u (.clk_sys, .nrst, .spi_cs_n, .spi_sclk, .spi_din, .spi_dout,
      .tx_gain_pins, .sixth_gain_pin, .pa_enable, .fuse_dc_i, .fuse_dc_q, .trim_lo_phase, .pa_bias_dac_on,
      .pa_bias_current_ua, .tx_gain_atten, .tx_dc_i_code, .tx_dc_q_code, .dc_i_pos_ua, .dc_i_neg_ua,
      .dc_q_pos_ua, .dc_q_neg_ua, .tx_lo_phase_code);
   tpb_ctrl_model ctl_u (.clk_sys, .spi_cs_n, .spi_sclk, .spi_din, .spi_dout);
   // ------------------------------------------------------------
   // clock, hang guard and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // about 5000 cycles are needed; the ceiling is generous
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         $display("mismatch at %0t: run did not finish", $time);
         final_report();
      end
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [9:0] d);
      ctl_u.xfer(1'b1, a, d, rd);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [9:0] exp);
      ctl_u.xfer(1'b0, a, 10'h000, rd);
      chk(rd, exp);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset_values;
      rdchk(5'h1c, 10'h0c0);
      rdchk(5'h1d, 10'h3f0);
      rdchk(5'h1e, 10'h080);
      rdchk(5'h1f, 10'h000);
      $display("test reset values done");
   endtask
   task automatic test_write_back;
      wr(5'h1b, 10'h3ff);
      rdchk(5'h1b, 10'h000);
      wr(5'h1c, 10'h2ff);
      wr(5'h1e, 10'h09f); // reserved bits left at 0010
      wr(5'h1f, 10'h3e1);
      rdchk(5'h1c, 10'h2ff);
      rdchk(5'h1e, 10'h09f);
      rdchk(5'h1f, 10'h3e1);
      chk(10'(pa_bias_current_ua), 10'h13b);
      chk(10'(tx_lo_phase_code), 10'h00f);
      chk(10'(tx_dc_i_code), 10'h003);
      chk(dc_i_neg_ua, 10'h060);
      chk(dc_q_pos_ua, 10'h300);
      $display("test write back done");
   endtask
   task automatic test_gain_select;
      chk(10'(tx_gain_atten), 10'h02a);
      sixth_gain_pin <= 1'b0;
      wr(5'h1d, 10'h3f2);
      chk(10'(tx_gain_atten), 10'h02a);
      wr(5'h1d, 10'h3f0);
      chk(10'(tx_gain_atten), 10'h00a);
      wr(5'h1d, 10'h151);
      tx_gain_pins <= 5'h1f;
      repeat (6) @(posedge clk_sys);
      chk(10'(tx_gain_atten), 10'h015);
      $display("test gain select done");
   endtask
   task automatic test_trim_select;
      wr(5'h1d, 10'h3f4); // reserved bit 3 left at 0
      chk(10'(tx_dc_q_code), 10'h01f);
      chk(dc_q_neg_ua, 10'h3e0);
      chk(dc_i_pos_ua, 10'h3c0);
      wr(5'h1e, 10'h0bf);
      chk(10'(tx_lo_phase_code), 10'h01f);
      $display("test trim select done");
   endtask
   task automatic test_turn_on_delay;
      int n [5];
      int codes [5] = '{0, 1, 2, 3, 15};
      foreach (codes[k]) begin
         wr(5'h1c, {codes[k][3:0], 6'h00});
         pa_enable <= 1'b1;
         n[k] = 0;
         while (pa_bias_dac_on !== 1'b1 && n[k] < 200) begin
            @(negedge clk_sys);
            n[k]++;
         end
         @(posedge clk_sys);
         pa_enable <= 1'b0;
         repeat (8) @(posedge clk_sys);
         chk(10'(pa_bias_dac_on), 10'h000);
      end
      foreach (codes[k]) chk(10'(n[k] - n[1]), 10'((codes[k] > 1 ? codes[k] - 1 : 0) * STEP));
      chk(10'(pa_bias_current_ua), 10'h000);
      $display("test turn on delay done");
   endtask
   // reset for three cycles, then the scenarios in order
   initial begin
      nrst = 1'b0;
      tx_gain_pins = 5'h0a;
      sixth_gain_pin = 1'b1;
      pa_enable = 1'b0;
      fuse_dc_i = 5'h03;
      fuse_dc_q = 5'h07;
      trim_lo_phase = 5'h0f;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      test_reset_values();
      test_write_back();
      test_gain_select();
      test_trim_select();
      test_turn_on_delay();
      final_report();
   end
endmodule // test_tx_pa_bias_config_regs
bind tpb_config_regs tpb_config_chk chk_u (.clk_sys, .nrst, .spi_cs_n, .spi_dout, .pa_enable, .fuse_dc_i,
   .trim_lo_phase, .pa_bias_dac_on, .pa_bias_current_ua, .tx_dc_i_code, .tx_dc_q_code, .dc_i_pos_ua,
   .dc_i_neg_ua, .dc_q_pos_ua, .dc_q_neg_ua, .tx_lo_phase_code);
`default_nettype wire
